// ---- pkg/adcsr_defs.svh ----
// adcsr_defs.svh: offsets, field positions, reset values and counts
// assumes inclusion by bare name from files that need the constants
`ifndef ADCSR_DEFS_SVH
`define ADCSR_DEFS_SVH

`define ADCSR_REG_CTRL   12'h000
`define ADCSR_REG_STAT   12'h004
`define ADCSR_REG_RESULT 12'h008

`define ADCSR_DEB_RST    16'h0004
`define ADCSR_CONV_RST   16'h0040

`define ADCSR_ST_CS      0
`define ADCSR_ST_EOC     1
`define ADCSR_ST_BUSY    2
`define ADCSR_ST_PD      3

`define ADCSR_ADDR_PD    4'he
`define ADCSR_LEN8       2'b01
`define ADCSR_LEN16      2'b11
`define ADCSR_N8         5'd8
`define ADCSR_N12        5'd12
`define ADCSR_N16        5'd16
`define ADCSR_ADDR_EDGE  5'd4
`define ADCSR_CMD_BITS   4'd8
`define ADCSR_PAD        4'h0
`define ADCSR_SIGN_FLIP  12'h800

`endif

// ---- pkg/adcsr_pkg.sv ----
// adcsr_pkg: types shared by the serial result control block
// assumes no surroundings beyond the design and bench files that import it
package adcsr_pkg;

   typedef struct packed {
      logic cs_n;
      logic io_clk;
      logic data_in;
   } adcsr_pin_in_t;

   typedef struct packed {
      logic [3:0] input_address_field;
      logic       length_select_high;
      logic       length_select_low;
      logic       bit_order_bit;
      logic       code_format_bit;
   } adcsr_cmd_t;

   typedef enum {st_io, st_conv} adcsr_state_t;

endpackage

// ---- rtl/adcsr_sync.sv ----
// adcsr_sync: three-stage pin synchroniser with agreement filter
// assumes d is asynchronous to clk; q moves when stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module adcsr_sync #(
   parameter int unsigned W   = 3,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= RST;
         s2_ff <= RST;
         s3_ff <= RST;
      end else if (ce) begin
         s1_ff <= d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < W; gi++) begin : g_bit
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               q[gi] <= RST[gi];
            end else if (ce && (s2_ff[gi] == s3_ff[gi])) begin
               q[gi] <= s3_ff[gi];
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// ---- rtl/adcsr_top.sv ----
// adcsr_top: serial command, result shift-out, eoc and select handling
// assumes pins are asynchronous to pclk and sample_code is pclk-synchronous
`timescale 1ns/100ps
`default_nettype none
`include "adcsr_defs.svh"

////////////////////////////////////////////////////////////////////////////
module adcsr_top #(
   parameter logic [15:0] CONV_CYCLES = `ADCSR_CONV_RST
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  ce,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire adcsr_pkg::adcsr_pin_in_t pins,
   input  wire logic [11:0]           sample_code,
   output logic                       data_out,
   output logic                       data_out_oe,
   output logic                       eoc,
   output logic                       power_down,
   output logic      [3:0]            input_address_field
);
   import adcsr_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisation and edge detection

   logic [2:0]    pin_q;
   adcsr_pin_in_t pin_s;
   logic          clk_prev_ff;
   logic          cs_deb_ff;
   logic [15:0]   deb_cnt_ff;
   logic [15:0]   deb_lim_ff;
   logic          deb_done;
   logic          cs_fall;
   logic          active;
   logic          rise;
   logic          fall;

   adcsr_sync #(
      .W   (3),
      .RST (3'h4)
   ) u_sync (
      .clk   (pclk),
      .rst_n (presetn),
      .ce    (ce),
      .d     (pins),
      .q     (pin_q)
   );

   assign pin_s = adcsr_pin_in_t'(pin_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_prev_ff <= 1'b0;
      end else if (ce) begin
         clk_prev_ff <= pin_s.io_clk;
      end
   end

   // select is filtered by a counted debounce before it moves the state;
   // the output float below does not wait for it
   assign deb_done = (pin_s.cs_n != cs_deb_ff) && (deb_cnt_ff >= deb_lim_ff);
   assign cs_fall  = deb_done && cs_deb_ff;
   assign active   = !cs_deb_ff;
   assign rise     = active && pin_s.io_clk && !clk_prev_ff;
   assign fall     = active && !pin_s.io_clk && clk_prev_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cs_deb_ff  <= 1'b1;
         deb_cnt_ff <= 16'h0000;
      end else if (ce) begin
         if (pin_s.cs_n == cs_deb_ff) begin
            deb_cnt_ff <= 16'h0000;
         end else if (deb_done) begin
            cs_deb_ff  <= pin_s.cs_n;
            deb_cnt_ff <= 16'h0000;
         end else begin
            deb_cnt_ff <= deb_cnt_ff + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // serial sequencer

   adcsr_state_t state_ff;
   adcsr_cmd_t   cmd_ff;
   logic [3:0]   rise_cnt_ff;
   logic [4:0]   fall_cnt_ff;
   logic [4:0]   fall_nxt;
   logic [4:0]   cur_len;
   logic [15:0]  conv_cnt_ff;
   logic [11:0]  res_ff;
   logic [11:0]  samp_ff;
   logic [11:0]  nxt_res;
   logic         signed_result_bit_ff;
   logic         low_end_first_flag_ff;
   logic [4:0]   len_ff;
   logic         eoc_ff;
   logic         dout_ff;
   logic         pd_ff;
   logic [3:0]   addr_ff;
   logic         last_edge;

   function automatic logic [4:0] len_bits(input logic [1:0] sel);
      case (sel)
         `ADCSR_LEN8:  len_bits = `ADCSR_N8;
         `ADCSR_LEN16: len_bits = `ADCSR_N16;
         default:      len_bits = `ADCSR_N12;
      endcase
   endfunction

   // result sits msb-justified in a 16-bit word with zero pad below it;
   // lsb-first starts n bits down from the top, so 8-bit drops the low
   // nibble and 16-bit leads with the pad
   function automatic logic out_bit(
      input logic [11:0] r,
      input logic        lo_first,
      input logic [4:0]  n,
      input logic [4:0]  i
   );
      logic [15:0] w;
      logic [4:0]  k;
      w = {r, `ADCSR_PAD};
      if (lo_first) begin
         k = 5'(`ADCSR_N16 - n + i);
      end else begin
         k = 5'(`ADCSR_N16 - 5'd1 - i);
      end
      out_bit = (i < n) ? w[k[3:0]] : 1'b0;
   endfunction

   assign fall_nxt  = 5'(fall_cnt_ff + 5'd1);
   assign cur_len   = len_bits({cmd_ff.length_select_high,
                                cmd_ff.length_select_low});
   assign last_edge = (fall_nxt == cur_len);
   assign nxt_res   = signed_result_bit_ff ?
                      (samp_ff ^ `ADCSR_SIGN_FLIP) : samp_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff              <= st_io;
         cmd_ff                <= '0;
         rise_cnt_ff           <= 4'h0;
         fall_cnt_ff           <= 5'h00;
         conv_cnt_ff           <= 16'h0000;
         res_ff                <= 12'h000;
         samp_ff               <= 12'h000;
         signed_result_bit_ff  <= 1'b0;
         low_end_first_flag_ff <= 1'b0;
         len_ff                <= `ADCSR_N12;
         eoc_ff                <= 1'b1;
         dout_ff               <= 1'b0;
         pd_ff                 <= 1'b1;
         addr_ff               <= 4'h0;
      end else if (ce) begin
         if (cs_fall) begin
            // an abort leaves res_ff alone so the old result goes out
            state_ff    <= st_io;
            eoc_ff      <= 1'b1;
            rise_cnt_ff <= 4'h0;
            fall_cnt_ff <= 5'h00;
            dout_ff     <= out_bit(res_ff, low_end_first_flag_ff,
                                   len_ff, 5'h00);
         end else begin
            case (state_ff)
               st_io: begin
                  if (rise && (rise_cnt_ff < `ADCSR_CMD_BITS)) begin
                     cmd_ff      <= {cmd_ff[6:0], pin_s.data_in};
                     rise_cnt_ff <= rise_cnt_ff + 4'h1;
                  end
                  if (fall) begin
                     fall_cnt_ff <= fall_nxt;
                     dout_ff     <= out_bit(res_ff, low_end_first_flag_ff,
                                            len_ff, fall_nxt);
                     if (fall_nxt == `ADCSR_ADDR_EDGE) begin
                        addr_ff <= cmd_ff[3:0];
                        pd_ff   <= (cmd_ff[3:0] == `ADCSR_ADDR_PD);
                     end
                     if (last_edge) begin
                        // order and length take hold for the next cycle
                        low_end_first_flag_ff <= cmd_ff.bit_order_bit;
                        len_ff      <= cur_len;
                        fall_cnt_ff <= 5'h00;
                        rise_cnt_ff <= 4'h0;
                        if (pd_ff) begin
                           dout_ff <= out_bit(res_ff, cmd_ff.bit_order_bit,
                                              cur_len, 5'h00);
                        end else begin
                           state_ff    <= st_conv;
                           eoc_ff      <= 1'b0;
                           dout_ff     <= 1'b0;
                           conv_cnt_ff <= CONV_CYCLES;
                           samp_ff     <= sample_code;
                           signed_result_bit_ff <=
                              cmd_ff.code_format_bit;
                        end
                     end
                  end
               end
               st_conv: begin
                  if (conv_cnt_ff <= 16'h0001) begin
                     res_ff   <= nxt_res;
                     eoc_ff   <= 1'b1;
                     state_ff <= st_io;
                     dout_ff  <= out_bit(nxt_res, low_end_first_flag_ff,
                                         len_ff, 5'h00);
                  end else begin
                     conv_cnt_ff <= conv_cnt_ff - 16'h0001;
                  end
               end
               default: begin
                  state_ff <= st_io;
               end
            endcase
         end
      end
   end

   // the float follows the synchronised select, not the debounced one
   assign data_out_oe         = !pin_s.cs_n;
   assign data_out            = dout_ff;
   assign eoc                 = eoc_ff;
   assign power_down          = pd_ff;
   assign input_address_field = addr_ff;

   ////////////////////////////////////////////////////////////////////////
   // apb slave: read data is captured in the setup phase

   logic        hit;
   logic        wr_acc;
   logic [31:0] stat_w;
   logic [31:0] prdata_ff;

   assign hit    = (paddr == `ADCSR_REG_CTRL) ||
                   (paddr == `ADCSR_REG_STAT) ||
                   (paddr == `ADCSR_REG_RESULT);
   assign wr_acc = ce && psel && penable && pwrite;
   assign pready  = ce;
   assign pslverr = psel && penable && !hit;
   assign prdata  = prdata_ff;

   always_comb begin
      stat_w                 = 32'h0000_0000;
      stat_w[`ADCSR_ST_CS]   = cs_deb_ff;
      stat_w[`ADCSR_ST_EOC]  = eoc_ff;
      stat_w[`ADCSR_ST_BUSY] = (state_ff == st_conv);
      stat_w[`ADCSR_ST_PD]   = pd_ff;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         deb_lim_ff <= `ADCSR_DEB_RST;
      end else if (wr_acc && (paddr == `ADCSR_REG_CTRL)) begin
         deb_lim_ff <= pwdata[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (ce && psel && !penable) begin
         case (paddr)
            `ADCSR_REG_CTRL:   prdata_ff <= {16'h0000, deb_lim_ff};
            `ADCSR_REG_STAT:   prdata_ff <= stat_w;
            `ADCSR_REG_RESULT: prdata_ff <= {20'h00000, res_ff};
            default:           prdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_conv_zero;
      state_ff == st_conv |-> !dout_ff && !eoc_ff;
   endproperty
   a_conv_zero: assert property (p_conv_zero)
      else $error("output not zero during conversion");

   property p_io_eoc_high;
      state_ff == st_io |-> eoc_ff;
   endproperty
   a_io_eoc_high: assert property (p_io_eoc_high)
      else $error("eoc low outside conversion");

   property p_inhibit;
      ce && cs_deb_ff && pin_s.cs_n
         |=> $stable(fall_cnt_ff) && $stable(cmd_ff);
   endproperty
   a_inhibit: assert property (p_inhibit)
      else $error("state moved while deselected");

   property p_conv_start;
      ce && fall && !cs_fall && state_ff == st_io && last_edge && !pd_ff
         |=> !eoc_ff ##1 !eoc_ff;
   endproperty
   a_conv_start: assert property (p_conv_start)
      else $error("eoc did not fall at last edge");

   property p_conv_end;
      ce && !cs_fall && state_ff == st_conv && conv_cnt_ff == 16'h0001
         |=> eoc_ff && state_ff == st_io && res_ff == $past(nxt_res);
   endproperty
   a_conv_end: assert property (p_conv_end)
      else $error("result not latched as eoc rose");

   property p_msb_first;
      $rose(eoc_ff) && !low_end_first_flag_ff |-> dout_ff == res_ff[11];
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("first bit is not the msb");

   property p_pad_first;
      $rose(eoc_ff) && low_end_first_flag_ff && len_ff == `ADCSR_N16
         |-> !dout_ff;
   endproperty
   a_pad_first: assert property (p_pad_first)
      else $error("lsb-first 16-bit did not lead with pad");

   property p_pd_enter;
      ce && fall && !cs_fall && state_ff == st_io && fall_cnt_ff == 5'd3
         && cmd_ff[3:0] == `ADCSR_ADDR_PD |=> pd_ff;
   endproperty
   a_pd_enter: assert property (p_pd_enter)
      else $error("power-down not entered at fourth edge");

   property p_cs_reset;
      ce && cs_fall |=> fall_cnt_ff == 5'h00 && eoc_ff && state_ff == st_io;
   endproperty
   a_cs_reset: assert property (p_cs_reset)
      else $error("select fall did not reset");

   property p_signed;
      ce && !cs_fall && state_ff == st_conv && conv_cnt_ff == 16'h0001
         && signed_result_bit_ff |=> res_ff[11] != $past(samp_ff[11]);
   endproperty
   a_signed: assert property (p_signed)
      else $error("signed code sign bit wrong");

   property p_pd_no_conv;
      pd_ff && state_ff == st_io && !cs_fall |=> state_ff == st_io;
   endproperty
   a_pd_no_conv: assert property (p_pd_no_conv)
      else $error("conversion started in power-down");

endmodule

`default_nettype wire

// ---- testbench/adc_serial_result_control_bench.sv ----
// adc_serial_result_control_bench: self-checking bench for adcsr_top
// assumes the host model owns the pins; registers are reached over apb
`timescale 1ns/100ps
`default_nettype none
`include "adcsr_defs.svh"

module adc_serial_result_control_bench;
   import adcsr_pkg::*;
   localparam logic [15:0] CONV = 16'h0028;
   localparam logic [11:0] REFS [6] = '{12'h000, 12'hfff, 12'h800,
                                        12'h800, 12'hfff, 12'h000};
   logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0]   paddr, sample_code, res;
   logic [31:0]   pwdata, prdata, rd, seed, w;
   logic          data_out, data_out_oe, eoc, power_down, err, plo, valid;
   logic          ce;
   logic [3:0]    input_address_field, a;
   adcsr_pin_in_t pins;
   int            fail_count, n_compared, plen, lcur, k;

   adcsr_top #(.CONV_CYCLES(CONV)) adcsr_top_inst (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
      .sample_code(sample_code), .data_out(data_out),
      .data_out_oe(data_out_oe), .eoc(eoc), .power_down(power_down),
      .input_address_field(input_address_field));
   adcsr_host_model adcsr_host_model_inst (
      .pclk(pclk), .pins(pins), .data_out(data_out), .eoc(eoc));

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // model: bit i of the stored result in the order latched last frame
   function automatic logic xbit(input int i);
      logic [15:0] wd;
      wd = {res, 4'h0};
      return plo ? wd[16 - plen + i] : wd[15 - i];
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] ad,
                      input logic [31:0] wd);
      int t;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      if (t == 50)
         fail_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic conv_wait();
      int t;
      t = 0;
      while (eoc !== 1'b0 && t < 20) begin
         @(posedge pclk);
         t++;
      end
      check(eoc, 0);
      repeat (2) @(posedge pclk);
      check(data_out, 0);
      while (eoc !== 1'b1 && t < CONV + 40) begin
         @(posedge pclk);
         t++;
      end
      check(eoc, 1);
      check(t > CONV, 1);
      repeat (8) @(posedge pclk);
   endtask

   // one frame; bits that this and the previous length both cover are
   // compared, since a length change may spoil the overlap otherwise
   task automatic cyc(input logic [3:0] ad, input logic [1:0] ln,
                      input logic lo, input logic fmt, input logic [11:0] c);
      int m;
      sample_code <= c;
      lcur = (ln == `ADCSR_LEN8) ? 8 : (ln == `ADCSR_LEN16) ? 16 : 12;
      adcsr_host_model_inst.xfer({ad, ln, lo, fmt}, lcur);
      m = (lcur < plen) ? lcur : plen;
      for (int i = 0; i < m; i++)
         if (valid)
            check(adcsr_host_model_inst.got[i], xbit(i));
      check(adcsr_host_model_inst.eoc_ok, 1);
      check(input_address_field, ad);
      check(power_down, ad == `ADCSR_ADDR_PD);
      plen = lcur;
      plo = lo;
      if (ad != `ADCSR_ADDR_PD) begin
         conv_wait();
         res = c ^ (fmt ? `ADCSR_SIGN_FLIP : 12'h000);
         valid = 1'b1;
         apb(1'b0, `ADCSR_REG_RESULT, 32'h0);
         check(rd, {20'h0, res});
      end else begin
         repeat (20) @(posedge pclk);
         check(eoc, 1);
      end
   endtask

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // whole run is near 25 us; this only cuts a hang short
   initial begin
      #200000;
      fail_count++;
      test_done();
   end

   initial begin
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      sample_code = 12'h000;
      seed = 32'hbfc5;
      res = 12'h000;
      valid = 1'b0;
      plo = 1'b0;
      plen = 12;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check(eoc, 1);
      check(power_down, 1);
      check(data_out_oe, 0);
      apb(1'b0, `ADCSR_REG_CTRL, 32'h0);
      check(rd, 32'h4);
      apb(1'b1, `ADCSR_REG_CTRL, 32'h6);
      apb(1'b0, `ADCSR_REG_CTRL, 32'h0);
      check(rd, 32'h6);
      apb(1'b0, `ADCSR_REG_STAT, 32'h0);
      check(rd, 32'hb);
      apb(1'b0, 12'h00c, 32'h0);
      check(err, 1);
      check(rd, 0);
      adcsr_host_model_inst.sel(1'b0);
      cyc(`ADCSR_ADDR_PD, 2'b00, 1'b0, 1'b0, 12'h000);
      for (k = 0; k < 12; k++) begin
         w = rnd();
         a = w[15:12] % 4'he;
         cyc((k == 6) ? `ADCSR_ADDR_PD : a, k[1:0], k[2], k[3] ^ k[0],
             (k < 6) ? REFS[k] : w[11:0]);
      end
      // abort: select pulses high after the frame and is debounced low
      // again well inside the conversion, so the old result survives
      sample_code <= w[11:0] ^ 12'h5a5;
      adcsr_host_model_inst.xfer({4'h5, 2'b11, 1'b0, 1'b1}, 16);
      adcsr_host_model_inst.sel(1'b1);
      check(data_out_oe, 0);
      adcsr_host_model_inst.sel(1'b0);
      check(eoc, 1);
      check(data_out, xbit(0));
      cyc(4'h2, 2'b11, 1'b0, 1'b0, 12'h3c5);
      adcsr_host_model_inst.sel(1'b1);
      adcsr_host_model_inst.xfer(8'hff, 3);
      adcsr_host_model_inst.sel(1'b0);
      check(data_out_oe, 1);
      check(data_out, xbit(0));
      cyc(4'h9, 2'b01, 1'b1, 1'b1, w[23:12]);
      apb(1'b1, `ADCSR_REG_RESULT, 32'hfff);
      apb(1'b0, `ADCSR_REG_RESULT, 32'h0);
      check(rd, {20'h0, res});
      // clock enable low: the bus stalls and no state moves
      ce <= 1'b0;
      repeat (5) @(posedge pclk);
      check(pready, 0);
      check(eoc, 1);
      check(data_out, xbit(0));
      ce <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `ADCSR_REG_CTRL, 32'h0);
      check(rd, 32'h6);
      test_done();
   end
endmodule

`default_nettype wire

// ---- testbench/adcsr_host_model.sv ----
// adcsr_host_model: host serial port driving select, shift clock, command
// assumes sel and xfer are called from a pclk rising edge
`timescale 1ns/100ps
`default_nettype none

module adcsr_host_model (
   input  wire logic                     pclk,
   output var  adcsr_pkg::adcsr_pin_in_t pins,
   input  wire logic                     data_out,
   input  wire logic                     eoc
);
   import adcsr_pkg::*;
   logic [15:0] got;
   logic        eoc_ok;

   initial begin
      pins = 3'b100;
      got = 16'h0000;
      eoc_ok = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // select moves, then the shift clock idles low past the debounce
   task automatic sel(input logic lvl);
      pins.cs_n <= lvl;
      repeat (20) @(posedge pclk);
   endtask

   // one frame of n clocks, 40 ns per phase; the clock stands still
   // outside frames and data_in toggles once the command is in, so a
   // stale level is never mistaken for a held one
   task automatic xfer(input logic [7:0] cmd, input int n);
      eoc_ok = 1'b1;
      for (int i = 0; i < n; i++) begin
         pins.data_in <= (i < 8) ? cmd[7 - i] : ~pins.data_in;
         repeat (4) @(posedge pclk);
         pins.io_clk <= 1'b1;
         repeat (4) @(posedge pclk);
         got[i] = data_out;
         eoc_ok = eoc_ok & eoc;
         pins.io_clk <= 1'b0;
      end
   endtask
endmodule

`default_nettype wire
